//--- include/eht_defines.svh
// Offsets, field layout, reset values and sizes of the echo hybrid tap registers
`ifndef EHT_DEFINES_SVH
`define EHT_DEFINES_SVH

`define EHT_ADDR_W        8
`define EHT_WEIGHT_W      8
`define EHT_WEIGHT_MSB    7
`define EHT_WEIGHT_LSB    0
`define EHT_FILTER_TAPS   8
`define EHT_TAP_COUNT     4
`define EHT_TAP_IDX_W     2
`define EHT_TAP1_ADDR     8'h2d
`define EHT_TAP2_ADDR     8'h2e
`define EHT_TAP3_ADDR     8'h2f
`define EHT_TAP4_ADDR     8'h30
`define EHT_TAP1_RESET    8'h00
`define EHT_TAP2_RESET    8'h00
`define EHT_TAP3_RESET    8'h00
`define EHT_TAP4_RESET    8'h00
`define EHT_UNMAPPED_DATA 8'h00

`endif

//--- include/eht_pkg.sv
// Types shared by the echo hybrid tap block
package eht_pkg;
`include "eht_defines.svh"

    typedef logic [`EHT_ADDR_W-1:0]    eht_addr_t;
    typedef logic [`EHT_WEIGHT_W-1:0]  eht_weight_t;
    typedef logic [`EHT_TAP_IDX_W-1:0] eht_tap_idx_t;

endpackage : eht_pkg

//--- logic/eht_tap_coef.sv
// One tap coefficient register with its stage-active flag
`timescale 1ns/1ps
`include "eht_defines.svh"

module eht_tap_coef
    import eht_pkg::*;
#(
    parameter eht_weight_t RESET_VAL = `EHT_TAP1_RESET
)(
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_wr_en,
    input  wire eht_weight_t i_wr_data,
    output eht_weight_t      o_weight,
    output logic             o_active
);

    eht_weight_t next_weight;
    logic        next_active;

    always_comb
    begin
        next_weight = o_weight;
        if (i_wr_en)
        begin
            next_weight = i_wr_data;
        end
        next_active = (next_weight != '0);
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_weight <= RESET_VAL;
            o_active <= 1'b0;
        end
        else
        begin
            o_weight <= next_weight;
            o_active <= next_active;
        end
    end

endmodule : eht_tap_coef

//--- logic/eht_taps.sv
// Coefficient registers and stage weights for hybrid filter taps one to four
`timescale 1ns/1ps
`include "eht_defines.svh"

// Behaviour
// - Hybrid filter has eight host-programmed tap weights
// - Register 0x2d weights the first stage
// - Register 0x2e weights the second stage
// - Register 0x2f weights the third stage
// - Register 0x30 weights the fourth stage
// - All-zero coefficient makes its stage inactive
// - All four coefficients reset to zero
// - Each coefficient is 8-bit read/write, reads back
module eht_taps
    import eht_pkg::*;
(
    input  wire logic                      i_clk,
    input  wire logic                      i_rst,
    input  wire eht_addr_t                 i_reg_addr,
    input  wire logic                      i_reg_wr,
    input  wire eht_weight_t               i_reg_wdata,
    input  wire logic                      i_reg_rd,
    output eht_weight_t                    o_reg_rdata,
    output logic                           o_reg_rvalid,
    output logic                           o_reg_hit,
    output eht_weight_t                    o_first_tap_weight,
    output eht_weight_t                    o_second_tap_weight,
    output eht_weight_t                    o_third_tap_weight,
    output eht_weight_t                    o_fourth_tap_weight,
    output logic [`EHT_TAP_COUNT-1:0]      o_tap_active
);

    localparam eht_addr_t TAP_ADDR [`EHT_TAP_COUNT] = '{
        `EHT_TAP1_ADDR, `EHT_TAP2_ADDR, `EHT_TAP3_ADDR, `EHT_TAP4_ADDR
    };
    localparam eht_weight_t TAP_RESET [`EHT_TAP_COUNT] = '{
        `EHT_TAP1_RESET, `EHT_TAP2_RESET, `EHT_TAP3_RESET, `EHT_TAP4_RESET
    };

    eht_weight_t                weights [`EHT_TAP_COUNT];
    logic [`EHT_TAP_COUNT-1:0]  active;
    logic [`EHT_TAP_COUNT-1:0]  wr_sel;
    eht_weight_t                next_rdata;
    logic                       next_rvalid;
    logic                       next_hit;

    // Address decode shared by the write and read paths
    function automatic logic tap_hit(input eht_addr_t addr, output eht_tap_idx_t idx);
        logic hit;
        hit = 1'b0;
        idx = '0;
        for (int k = 0; k < `EHT_TAP_COUNT; k++)
        begin
            if (addr == TAP_ADDR[k])
            begin
                hit = 1'b1;
                idx = k[`EHT_TAP_IDX_W-1:0];
            end
        end
        return hit;
    endfunction : tap_hit

    // Write strobes, one per coefficient
    always_comb
    begin
        eht_tap_idx_t widx;
        logic         whit;
        widx   = '0;
        wr_sel = '0;
        whit   = tap_hit(i_reg_addr, widx);
        if (i_reg_wr && whit)
        begin
            wr_sel[widx] = 1'b1;
        end
    end

    // Coefficient storage, first four of the eight taps
    generate
        for (genvar t = 0; t < `EHT_TAP_COUNT; t++)
        begin : g_tap
            eht_tap_coef #(
                .RESET_VAL (TAP_RESET[t])
            ) u_coef (
                .i_clk     (i_clk),
                .i_rst     (i_rst),
                .i_wr_en   (wr_sel[t]),
                .i_wr_data (i_reg_wdata),
                .o_weight  (weights[t]),
                .o_active  (active[t])
            );
        end
    endgenerate

    // Stage weights to the echo-reduction datapath
    assign o_first_tap_weight  = weights[0];
    assign o_second_tap_weight = weights[1];
    assign o_third_tap_weight  = weights[2];
    assign o_fourth_tap_weight = weights[3];
    assign o_tap_active        = active;

    // Read path, data one cycle after the strobe
    always_comb
    begin
        eht_tap_idx_t ridx;
        logic         rhit;
        ridx        = '0;
        rhit        = tap_hit(i_reg_addr, ridx);
        next_rvalid = i_reg_rd;
        next_hit    = i_reg_rd && rhit;
        next_rdata  = `EHT_UNMAPPED_DATA;
        if (i_reg_rd && rhit)
        begin
            next_rdata = weights[ridx];
        end
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_reg_rdata  <= `EHT_UNMAPPED_DATA;
            o_reg_rvalid <= 1'b0;
            o_reg_hit    <= 1'b0;
        end
        else
        begin
            o_reg_rdata  <= next_rdata;
            o_reg_rvalid <= next_rvalid;
            o_reg_hit    <= next_hit;
        end
    end

    // Checks
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    sequence s_write(eht_addr_t a);
        i_reg_wr && (i_reg_addr == a);
    endsequence

    sequence s_read_quiet(eht_addr_t a);
        i_reg_rd && !i_reg_wr && (i_reg_addr == a);
    endsequence

    a_tap1_write_applies: assert property (
        s_write(`EHT_TAP1_ADDR) |=> (o_first_tap_weight == $past(i_reg_wdata))
    ) else $error("First tap weight did not take the written value");

    a_tap2_write_applies: assert property (
        s_write(`EHT_TAP2_ADDR) |=> (o_second_tap_weight == $past(i_reg_wdata))
    ) else $error("Second tap weight did not take the written value");

    a_tap3_write_applies: assert property (
        s_write(`EHT_TAP3_ADDR) |=> (o_third_tap_weight == $past(i_reg_wdata))
    ) else $error("Third tap weight did not take the written value");

    a_tap4_write_applies: assert property (
        s_write(`EHT_TAP4_ADDR) |=> (o_fourth_tap_weight == $past(i_reg_wdata))
    ) else $error("Fourth tap weight did not take the written value");

    a_zero_stage_idle: assert property (
        (o_tap_active[0] == (o_first_tap_weight != 8'h00))
        && (o_tap_active[1] == (o_second_tap_weight != 8'h00))
        && (o_tap_active[2] == (o_third_tap_weight != 8'h00))
        && (o_tap_active[3] == (o_fourth_tap_weight != 8'h00))
    ) else $error("Stage active flag disagrees with its coefficient");

    a_odd_reset_zero: assert property (
        $past(i_rst) |-> (o_first_tap_weight == 8'h00) && (o_third_tap_weight == 8'h00)
            && !o_tap_active[0] && !o_tap_active[2]
    ) else $error("First or third coefficient not zero after reset");

    a_even_reset_zero: assert property (
        $past(i_rst) |-> (o_second_tap_weight == 8'h00) && (o_fourth_tap_weight == 8'h00)
            && !o_tap_active[1] && !o_tap_active[3]
    ) else $error("Second or fourth coefficient not zero after reset");

    a_read_back_tap: assert property (
        s_write(`EHT_TAP3_ADDR) ##1 s_read_quiet(`EHT_TAP3_ADDR)
            |=> o_reg_rvalid && o_reg_hit && (o_reg_rdata == $past(i_reg_wdata, 2))
    ) else $error("Coefficient read did not return the last value written");

    a_coef_holds: assert property (
        !(i_reg_wr && (i_reg_addr == `EHT_TAP1_ADDR)) |=> $stable(o_first_tap_weight)
    ) else $error("First tap weight changed without a write");

    a_unmapped_zero: assert property (
        i_reg_rd && (i_reg_addr > `EHT_TAP4_ADDR)
            |=> o_reg_rvalid && !o_reg_hit && (o_reg_rdata == 8'h00)
    ) else $error("Unmapped read returned nonzero data");

endmodule : eht_taps

//--- tb/tb_top.sv
// Self-checking bench for the echo hybrid tap coefficient registers
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin miscompares++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (b)); end end

module tb_top
    import eht_pkg::*;
;
    logic        i_clk = 1'b0;
    logic        i_rst = 1'b1;
    eht_addr_t   addr  = 8'h00;
    logic        wr_en = 1'b0;
    logic        rd_en = 1'b0;
    eht_weight_t wdata = 8'h00;
    eht_weight_t rdata;
    logic        rvalid;
    logic        hit;
    eht_weight_t w [4];
    logic [3:0]  act;
    eht_weight_t vals [4] = '{8'h81, 8'hff, 8'h01, 8'h7e};
    int          miscompares = 0;
    int          compares = 0;

    always #2 i_clk = ~i_clk;

    eht_taps u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_reg_addr(addr), .i_reg_wr(wr_en),
        .i_reg_wdata(wdata), .i_reg_rd(rd_en), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
        .o_reg_hit(hit), .o_first_tap_weight(w[0]), .o_second_tap_weight(w[1]),
        .o_third_tap_weight(w[2]), .o_fourth_tap_weight(w[3]), .o_tap_active(act));

    task automatic wr(input eht_addr_t a, input eht_weight_t d, input logic rd_too);
        @(negedge i_clk);
        addr = a;
        wdata = d;
        wr_en = 1'b1;
        rd_en = rd_too;
        @(negedge i_clk);
        wr_en = 1'b0;
        rd_en = 1'b0;
    endtask : wr

    task automatic rd(input eht_addr_t a, input eht_weight_t e, input logic h);
        @(negedge i_clk);
        addr = a;
        rd_en = 1'b1;
        @(negedge i_clk);
        rd_en = 1'b0;
        `CHK(rvalid, 1'b1)
        `CHK(hit, h)
        `CHK(rdata, e)
    endtask : rd

    task automatic all_zero();
        for (int k = 0; k < 4; k++)
        begin
            `CHK(w[k], 8'h00)
            rd(8'h2d + 8'(k), 8'h00, 1'b1);
        end
        `CHK(act, 4'h0)
    endtask : all_zero

    task automatic t_map();
        for (int k = 0; k < 4; k++)
        begin
            wr(8'h2d + 8'(k), vals[k], 1'b0);
            `CHK(w[k], vals[k])
        end
        for (int k = 0; k < 4; k++)
        begin
            `CHK(w[k], vals[k])
            rd(8'h2d + 8'(k), vals[k], 1'b1);
        end
        `CHK(act, 4'hf)
        $display("test map done");
    endtask : t_map

    task automatic t_unmapped();
        wr(8'h2c, 8'h55, 1'b0);
        wr(8'h31, 8'h55, 1'b0);
        for (int k = 0; k < 4; k++)
            `CHK(w[k], vals[k])
        rd(8'h2c, 8'h00, 1'b0);
        rd(8'h31, 8'h00, 1'b0);
        $display("test unmapped done");
    endtask : t_unmapped

    task automatic t_same_cycle();
        wr(8'h2e, 8'h5a, 1'b0);
        wr(8'h2e, 8'h3c, 1'b1);
        `CHK(rvalid, 1'b1)
        `CHK(rdata, 8'h5a)
        `CHK(w[1], 8'h3c)
        $display("test same cycle done");
    endtask : t_same_cycle

    task automatic t_zero();
        logic [3:0] m;
        m = 4'hf;
        for (int k = 0; k < 4; k++)
        begin
            wr(8'h2d + 8'(k), 8'h00, 1'b0);
            m[k] = 1'b0;
            `CHK(act, m)
        end
        wr(8'h2f, 8'h80, 1'b0);
        `CHK(act, 4'h4)
        $display("test zero done");
    endtask : t_zero

    task automatic t_back_to_back();
        @(negedge i_clk);
        addr = 8'h2f;
        wdata = 8'h96;
        wr_en = 1'b1;
        @(negedge i_clk);
        wr_en = 1'b0;
        rd_en = 1'b1;
        `CHK(w[2], 8'h96)
        @(negedge i_clk);
        rd_en = 1'b0;
        `CHK(rvalid, 1'b1)
        `CHK(hit, 1'b1)
        `CHK(rdata, 8'h96)
        @(negedge i_clk);
        `CHK(rvalid, 1'b0)
        `CHK(rdata, 8'h00)
        $display("test back to back done");
    endtask : t_back_to_back

    task automatic t_mid_reset();
        for (int k = 0; k < 4; k++)
            wr(8'h2d + 8'(k), vals[k], 1'b0);
        @(negedge i_clk);
        i_rst = 1'b1;
        repeat (2) @(negedge i_clk);
        `CHK(act, 4'h0)
        `CHK(w[1], 8'h00)
        i_rst = 1'b0;
        all_zero();
        $display("test mid reset done");
    endtask : t_mid_reset

    task automatic tally_and_finish();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : tally_and_finish

    initial
    begin
        #8000;
        miscompares++;
        tally_and_finish();
    end

    initial
    begin
        repeat (12) @(negedge i_clk);
        i_rst = 1'b0;
        all_zero();
        $display("test reset done");
        t_map();
        t_unmapped();
        t_same_cycle();
        t_zero();
        t_back_to_back();
        t_mid_reset();
        tally_and_finish();
    end
endmodule : tb_top
